//--- hdl/tmr_regs.sv
// timer16 register interface: staged 16-bit access, compares, capture and irq flags over apb
//
// Added by the designer: the APB register port and the placing of the registers.
module tmr_regs
	import tmr_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        snapshot_pin,
	input  wire logic        cmp_out,
	input  wire logic        snap_src_cmp,
	output logic             wave_out_a,
	output logic             wave_out_b,
	output logic [3:0]       irq_req
);
	initial begin
		if (CNT_W != 16) $error("tmr_regs: CNT_W must be 16");
	end

	logic [7:0]  stage_reg;
	logic [15:0] count_value_reg;
	logic [15:0] match_reg_a_reg;
	logic [15:0] match_reg_b_reg;
	logic [15:0] snapshot_reg_reg;
	logic [7:0]  timer_irq_mask_reg;
	logic [7:0]  timer_irq_flags_reg;
	logic [7:0]  ctrl_reg;
	logic        gie_reg;
	logic        block_reg;
	logic        match_a_pend_reg;
	logic        match_b_pend_reg;
	logic        pin_d_reg;

	logic        wr;
	logic        rd;
	logic        mapped;
	logic [3:0]  mode;
	logic        snap_is_top;
	logic [15:0] top_val;
	logic        run;
	logic        at_top;
	logic        wrap_evt;
	logic        snap_evt;
	logic        edge_hit;
	logic        cnt_wr;
	logic [3:0]  ack_set;
	logic [3:0]  sw_clr;
	logic [3:0]  evt;
	logic        force_a;
	logic        force_b;

	function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	assign wr      = psel && penable && pwrite;
	assign rd      = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign mapped  = paddr[1:0] == 2'b00 && paddr <= OFF_GIE;
	assign pslverr = psel && penable && !mapped;
	assign mode    = ctrl_reg[CTRL_MODE_LSB +: 4];
	assign run     = ctrl_reg[CTRL_RUN];
	assign snap_is_top = mode == MODE_PFC_SNAP || mode == MODE_PC_SNAP
		|| mode == MODE_CTC_SNAP || mode == MODE_FAST_SNAP;
	assign top_val = snap_is_top ? snapshot_reg_reg
		: (mode == MODE_CTC_A ? match_reg_a_reg : MAX_VAL);
	assign at_top  = count_value_reg == top_val;
	assign cnt_wr  = wr && sel(paddr, OFF_CNT_LO);
	assign force_a = wr && sel(paddr, OFF_CTRL) && pwdata[CTRL_FORCE_A];
	assign force_b = wr && sel(paddr, OFF_CTRL) && pwdata[CTRL_FORCE_B];

	// edge select: one rising, zero falling; pin ignored when capture is top
	assign edge_hit = ctrl_reg[CTRL_EDGE] ? (snapshot_pin && !pin_d_reg)
		: (!snapshot_pin && pin_d_reg);
	assign snap_evt = snap_src_cmp ? 1'b0 : (edge_hit && !snap_is_top);

	// wrap point: max in normal/ctc modes; top otherwise (single-slope simplification)
	assign wrap_evt = run && !cnt_wr && (mode == MODE_NORMAL || mode == MODE_CTC_A
		|| mode == MODE_CTC_SNAP ? count_value_reg == MAX_VAL : at_top);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_d_reg <= 1'b0;
		end else begin
			pin_d_reg <= snap_src_cmp ? cmp_out : snapshot_pin;
		end
	end

	// staging byte: upper write parks here; lower read latches the upper half of the source
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage_reg <= 8'h00;
		end else if (wr && (sel(paddr, OFF_CNT_HI) || sel(paddr, OFF_MA_HI)
				|| sel(paddr, OFF_MB_HI) || sel(paddr, OFF_SNAP_HI))) begin
			stage_reg <= pwdata[7:0];
		end else if (rd && sel(paddr, OFF_CNT_LO)) begin
			stage_reg <= count_value_reg[15:8];
		end else if (rd && sel(paddr, OFF_SNAP_LO)) begin
			stage_reg <= snapshot_reg_reg[15:8];
		end else if (rd && sel(paddr, OFF_MA_LO)) begin
			stage_reg <= match_reg_a_reg[15:8];
		end else if (rd && sel(paddr, OFF_MB_LO)) begin
			stage_reg <= match_reg_b_reg[15:8];
		end
	end

	// counter: a processor write overrides counting; software should not rewrite it while running
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_value_reg <= 16'h0000;
		end else if (cnt_wr) begin
			count_value_reg <= {stage_reg, pwdata[7:0]};
		end else if (run) begin
			count_value_reg <= at_top ? 16'h0000 : count_value_reg + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			match_reg_a_reg <= 16'h0000;
			match_reg_b_reg <= 16'h0000;
		end else begin
			if (wr && sel(paddr, OFF_MA_LO)) begin
				match_reg_a_reg <= {stage_reg, pwdata[7:0]};
			end
			if (wr && sel(paddr, OFF_MB_LO)) begin
				match_reg_b_reg <= {stage_reg, pwdata[7:0]};
			end
		end
	end

	// capture register: snapshot on event, or written as top value when it serves as top
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			snapshot_reg_reg <= 16'h0000;
		end else if (wr && sel(paddr, OFF_SNAP_LO) && snap_is_top) begin
			snapshot_reg_reg <= {stage_reg, pwdata[7:0]};
		end else if (snap_evt) begin
			snapshot_reg_reg <= count_value_reg;
		end
	end

	// compare on every cycle while running; a counter write suppresses the match on the next timer clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			block_reg        <= 1'b0;
			match_a_pend_reg <= 1'b0;
			match_b_pend_reg <= 1'b0;
		end else begin
			block_reg        <= cnt_wr;
			match_a_pend_reg <= run && !cnt_wr && !block_reg
				&& count_value_reg == match_reg_a_reg;
			match_b_pend_reg <= run && !cnt_wr && !block_reg
				&& count_value_reg == match_reg_b_reg;
		end
	end

	// wave outputs toggle on real or forced matches; forced ones never reach the flags
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
		end else begin
			if (match_a_pend_reg || force_a) begin
				wave_out_a <= !wave_out_a;
			end
			if (match_b_pend_reg || force_b) begin
				wave_out_b <= !wave_out_b;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timer_irq_mask_reg <= MASK_RESET;
			ctrl_reg           <= CTRL_RESET;
			gie_reg            <= 1'b0;
		end else if (wr) begin
			if (sel(paddr, OFF_IRQ_MASK)) begin
				timer_irq_mask_reg <= pwdata[7:0] & IRQ_BITS_MASK;
			end
			if (sel(paddr, OFF_CTRL)) begin
				ctrl_reg <= {2'b00, pwdata[5:0]};
			end
			if (sel(paddr, OFF_GIE)) begin
				gie_reg <= pwdata[0];
			end
		end
	end

	// flag order: snap, match a, match b, wrap; set wins over any clear in the same cycle
	assign evt = {snap_is_top ? (run && at_top) : snap_evt,
		match_a_pend_reg, match_b_pend_reg, wrap_evt};
	assign sw_clr  = (wr && sel(paddr, OFF_IRQ_FLAG)) ? pwdata[5:2] : 4'h0;
	assign ack_set = (wr && sel(paddr, OFF_ACK)) ? pwdata[5:2] : 4'h0;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timer_irq_flags_reg <= FLAG_RESET;
		end else begin
			timer_irq_flags_reg[5:2] <= evt | (timer_irq_flags_reg[5:2]
				& ~sw_clr & ~ack_set);
			timer_irq_flags_reg[7:6] <= 2'b00;
			timer_irq_flags_reg[1:0] <= 2'b00;
		end
	end

	assign irq_req = gie_reg ? (timer_irq_flags_reg[5:2] & timer_irq_mask_reg[5:2])
		: 4'h0;

	// read data from flops; high-byte reads return the staging byte
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFF_CNT_LO:   prdata <= {24'h000000, count_value_reg[7:0]};
				OFF_MA_LO:    prdata <= {24'h000000, match_reg_a_reg[7:0]};
				OFF_MB_LO:    prdata <= {24'h000000, match_reg_b_reg[7:0]};
				OFF_SNAP_LO:  prdata <= {24'h000000, snapshot_reg_reg[7:0]};
				OFF_CNT_HI,
				OFF_MA_HI,
				OFF_MB_HI,
				OFF_SNAP_HI:  prdata <= {24'h000000, stage_reg};
				OFF_IRQ_MASK: prdata <= {24'h000000, timer_irq_mask_reg};
				OFF_IRQ_FLAG: prdata <= {24'h000000, timer_irq_flags_reg};
				OFF_CTRL:     prdata <= {24'h000000, ctrl_reg};
				OFF_GIE:      prdata <= {31'h00000000, gie_reg};
				default:      prdata <= 32'h0000_0000;
			endcase
		end
	end

	property p_block;
		@(posedge core_clk) disable iff (rst)
		cnt_wr |=> !match_a_pend_reg && !match_b_pend_reg;
	endproperty
	a_block: assert property (p_block) else $error("match not blocked after counter write");

	property p_match_a;
		@(posedge core_clk) disable iff (rst)
		match_a_pend_reg |=> timer_irq_flags_reg[BIT_MA];
	endproperty
	a_match_a: assert property (p_match_a) else $error("compare a flag not set");

	property p_match_b;
		@(posedge core_clk) disable iff (rst)
		(run && !cnt_wr && !block_reg && count_value_reg == match_reg_b_reg)
			|=> ##1 timer_irq_flags_reg[BIT_MB];
	endproperty
	a_match_b: assert property (p_match_b) else $error("compare b flag late");

	property p_force;
		@(posedge core_clk) disable iff (rst)
		(force_a && !match_a_pend_reg && !$past(match_a_pend_reg) && !timer_irq_flags_reg[BIT_MA])
			|=> ##1 (!timer_irq_flags_reg[BIT_MA] || $past(match_a_pend_reg));
	endproperty
	a_force: assert property (p_force) else $error("forced compare set flag");

	property p_irq;
		@(posedge core_clk) disable iff (rst)
		irq_req[3] == (gie_reg && timer_irq_mask_reg[BIT_SNAP] && timer_irq_flags_reg[BIT_SNAP]);
	endproperty
	a_irq: assert property (p_irq) else $error("capture request mismatch");

	property p_clr;
		@(posedge core_clk) disable iff (rst)
		(wr && sel(paddr, OFF_IRQ_FLAG) && pwdata[BIT_WRAP] && !wrap_evt) |=> !timer_irq_flags_reg[BIT_WRAP];
	endproperty
	a_clr: assert property (p_clr) else $error("wrap flag not cleared");

	property p_reserved;
		@(posedge core_clk) disable iff (rst)
		!timer_irq_flags_reg[1] && !timer_irq_mask_reg[1];
	endproperty
	a_reserved: assert property (p_reserved) else $error("read-only bit 1 set");

	property p_snap;
		@(posedge core_clk) disable iff (rst)
		snap_evt |=> snapshot_reg_reg == $past(count_value_reg) && timer_irq_flags_reg[BIT_SNAP];
	endproperty
	a_snap: assert property (p_snap) else $error("capture not taken");

	property p_top_pin;
		@(posedge core_clk) disable iff (rst)
		snap_is_top |-> !snap_evt;
	endproperty
	a_top_pin: assert property (p_top_pin) else $error("pin active while capture is top");

	property p_cnt_wr;
		@(posedge core_clk) disable iff (rst)
		cnt_wr |=> count_value_reg == {$past(stage_reg), $past(pwdata[7:0])};
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("counter write not coherent");

	property p_wrap;
		@(posedge core_clk) disable iff (rst)
		wrap_evt |=> timer_irq_flags_reg[BIT_WRAP];
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap flag not set");

	property p_top_flag;
		@(posedge core_clk) disable iff (rst)
		(snap_is_top && run && at_top) |=> timer_irq_flags_reg[BIT_SNAP];
	endproperty
	a_top_flag: assert property (p_top_flag) else $error("capture flag not set at top");

	property p_ack;
		@(posedge core_clk) disable iff (rst)
		(wr && sel(paddr, OFF_ACK) && pwdata[BIT_MA] && !match_a_pend_reg) |=> !timer_irq_flags_reg[BIT_MA];
	endproperty
	a_ack: assert property (p_ack) else $error("vector ack did not clear flag");

	property p_mask_bits;
		@(posedge core_clk) disable iff (rst)
		(timer_irq_mask_reg & ~IRQ_BITS_MASK) == 8'h00;
	endproperty
	a_mask_bits: assert property (p_mask_bits) else $error("unused mask bit set");

	property p_ma_wr;
		@(posedge core_clk) disable iff (rst)
		(wr && sel(paddr, OFF_MA_LO)) |=> match_reg_a_reg == {$past(stage_reg), $past(pwdata[7:0])};
	endproperty
	a_ma_wr: assert property (p_ma_wr) else $error("compare write not coherent");

	property p_stage;
		@(posedge core_clk) disable iff (rst)
		(wr && sel(paddr, OFF_CNT_HI)) |=> stage_reg == $past(pwdata[7:0]);
	endproperty
	a_stage: assert property (p_stage) else $error("upper byte not staged");

	property p_snap_rd;
		@(posedge core_clk) disable iff (rst)
		(rd && sel(paddr, OFF_SNAP_LO)) |=> stage_reg == $past(snapshot_reg_reg[15:8]);
	endproperty
	a_snap_rd: assert property (p_snap_rd) else $error("capture upper byte not latched");

	property p_match_b_flag;
		@(posedge core_clk) disable iff (rst)
		match_b_pend_reg |=> timer_irq_flags_reg[BIT_MB];
	endproperty
	a_match_b_flag: assert property (p_match_b_flag) else $error("compare b flag not set");


	c_match_a: cover property (@(posedge core_clk) disable iff (rst) match_a_pend_reg);
	c_wrap:    cover property (@(posedge core_clk) disable iff (rst) wrap_evt);
	c_snap:    cover property (@(posedge core_clk) disable iff (rst) snap_evt);
	c_irq:     cover property (@(posedge core_clk) disable iff (rst) |irq_req);
	c_force:   cover property (@(posedge core_clk) disable iff (rst) force_a);
endmodule

//--- hdl/tmr_pkg.sv
// package: register map, field positions, reset values and modes of the 16-bit timer register block
package tmr_pkg;
	localparam logic [7:0] OFF_CNT_HI   = 8'h00;
	localparam logic [7:0] OFF_CNT_LO   = 8'h04;
	localparam logic [7:0] OFF_MA_HI    = 8'h08;
	localparam logic [7:0] OFF_MA_LO    = 8'h0C;
	localparam logic [7:0] OFF_MB_HI    = 8'h10;
	localparam logic [7:0] OFF_MB_LO    = 8'h14;
	localparam logic [7:0] OFF_SNAP_HI  = 8'h18;
	localparam logic [7:0] OFF_SNAP_LO  = 8'h1C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFF_IRQ_FLAG = 8'h24;
	localparam logic [7:0] OFF_CTRL     = 8'h28;
	localparam logic [7:0] OFF_ACK      = 8'h2C;
	localparam logic [7:0] OFF_GIE      = 8'h30;
	// field positions shared by mask and flag registers
	localparam int BIT_SNAP  = 5;
	localparam int BIT_MA    = 4;
	localparam int BIT_MB    = 3;
	localparam int BIT_WRAP  = 2;
	localparam logic [7:0] IRQ_BITS_MASK = 8'h3C;
	localparam logic [7:0] MASK_RESET    = 8'h00;
	localparam logic [7:0] FLAG_RESET    = 8'h00;
	// control register fields
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_RUN       = 4;
	localparam int CTRL_EDGE      = 5;
	localparam int CTRL_FORCE_A   = 6;
	localparam int CTRL_FORCE_B   = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] MAX_VAL  = 16'hFFFF;
	localparam logic [3:0] MODE_NORMAL   = 4'h0;
	localparam logic [3:0] MODE_CTC_A    = 4'h4;
	localparam logic [3:0] MODE_PFC_SNAP = 4'h8;
	localparam logic [3:0] MODE_PC_SNAP  = 4'hA;
	localparam logic [3:0] MODE_CTC_SNAP = 4'hC;
	localparam logic [3:0] MODE_FAST_SNAP = 4'hE;
endpackage

//--- testbench/tmr_cpu_model.sv
// partner: apb master standing in for the processor core that reaches the timer registers
module tmr_cpu_model (
	input  wire logic        core_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
	end

	// one transfer; afterwards address and write data get inverted values so a late sample is caught
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err, output logic to);
		int n;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		to = 1'b1;
		rd = 32'h00000000;
		err = 1'b0;
		for (n = 0; n < 16; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1) begin
				to = 1'b0;
				rd = prdata;
				err = pslverr;
				break;
			end
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask
endmodule

//--- testbench/test_timer16_register_and_irq_interface.sv
// testbench: staged 16-bit access, compare, capture, wrap and flag scenarios of the timer registers
module test_timer16_register_and_irq_interface import tmr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic        core_clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic        snapshot_pin;
	logic        cmp_out;
	logic        snap_src_cmp;
	logic        wave_out_a;
	logic        wave_out_b;
	logic [3:0]  irq_req;
	int          bad_count;
	int          num_checks;
	int          i;
	int          j;
	int          k;
	int          exp16[3];
	integer      seed;
	logic [31:0] rv;
	logic        err;
	logic        to;
	logic [1:0]  wv;

	tmr_regs dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.snapshot_pin(snapshot_pin), .cmp_out(cmp_out), .snap_src_cmp(snap_src_cmp),
		.wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .irq_req(irq_req));

	tmr_cpu_model cpu (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));

	always #25 core_clk = ~core_clk;

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
		num_checks++;
		if ((got & msk) !== (exp & msk)) begin
			bad_count++;
			$display("mismatch at %0t: read %h expected %h", $time, got & msk, exp & msk);
		end
	endtask

	// ports are looked at mid-cycle so the updates of the last edge have landed
	task automatic chk_port(input logic [3:0] exp);
		@(negedge core_clk);
		num_checks++;
		if ({irq_req} !== exp) begin
			bad_count++;
			$display("mismatch at %0t: irq lines %h expected %h", $time, irq_req, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		cpu.xfer(w, a, d, rv, err, to);
		if (to !== 1'b0) begin
			bad_count++;
			$display("mismatch at %0t: no ready from the slave", $time);
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		acc(1'b0, a, 32'h00000000);
		chk(rv, e, m);
	endtask

	// upper byte goes to staging first, the lower write commits both
	task automatic w16(input logic [7:0] base, input logic [15:0] v);
		acc(1'b1, base, {24'h000000, v[15:8]});
		acc(1'b1, base + 8'h04, {24'h000000, v[7:0]});
	endtask

	task automatic r16(input logic [7:0] base, input logic [15:0] e);
		logic [7:0] lo;
		acc(1'b0, base + 8'h04, 32'h00000000);
		lo = rv[7:0];
		acc(1'b0, base, 32'h00000000);
		chk({16'h0000, rv[7:0], lo}, {16'h0000, e}, 32'h0000FFFF);
	endtask

	task automatic edge_to(input logic v);
		snapshot_pin <= v;
		repeat (6) @(posedge core_clk);
	endtask

	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		snapshot_pin = 1'b0;
		cmp_out = 1'b0;
		snap_src_cmp = 1'b0;
		bad_count = 0;
		num_checks = 0;
		seed = 32'h63BF79F2;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk(OFF_IRQ_MASK, MASK_RESET, 32'h000000FF);
		rd_chk(OFF_IRQ_FLAG, FLAG_RESET, 32'h000000FF);
		wr(OFF_IRQ_MASK, 32'h000000FF);
		rd_chk(OFF_IRQ_MASK, IRQ_BITS_MASK, 32'h000000FF);
		wr(OFF_IRQ_MASK, 32'h00000000);
		acc(1'b0, 8'h34, 32'h00000000);
		chk({31'h0, err}, 32'h00000001, 32'h00000001);
		for (i = 0; i < 4; i++) begin
			for (j = 0; j < 3; j++) begin
				exp16[j] = $random(seed) & 32'h0000FFFF;
				w16(8'(j * 8), 16'(exp16[j]));
			end
			for (j = 0; j < 3; j++)
				r16(8'(j * 8), 16'(exp16[j]));
		end
		w16(OFF_MA_HI, 16'h0010);
		w16(OFF_MB_HI, 16'h0020);
		w16(OFF_CNT_HI, 16'h0000);
		wr(OFF_IRQ_FLAG, 32'h0000003C);
		rd_chk(OFF_IRQ_FLAG, 32'h00000000, 32'h0000003C);
		wr(OFF_CTRL, 32'h00000010);
		repeat (60) @(posedge core_clk);
		wr(OFF_CTRL, 32'h00000000);
		rd_chk(OFF_IRQ_FLAG, 32'h00000018, 32'h0000003C);
		wr(OFF_IRQ_FLAG, 32'h00000010);
		rd_chk(OFF_IRQ_FLAG, 32'h00000008, 32'h0000003C);
		wr(OFF_IRQ_FLAG, 32'h00000000);
		rd_chk(OFF_IRQ_FLAG, 32'h00000008, 32'h0000003C);
		wr(OFF_IRQ_MASK, 32'h00000008);
		chk_port(4'h0);
		wr(OFF_GIE, 32'h00000001);
		chk_port(4'h2);
		wr(OFF_IRQ_MASK, 32'h00000000);
		chk_port(4'h0);
		wr(OFF_IRQ_MASK, 32'h00000008);
		wr(OFF_ACK, 32'h00000008);
		chk_port(4'h0);
		rd_chk(OFF_IRQ_FLAG, 32'h00000000, 32'h0000003C);
		w16(OFF_CNT_HI, 16'hFFF0);
		wr(OFF_IRQ_FLAG, 32'h0000003C);
		wr(OFF_CTRL, 32'h00000010);
		repeat (30) @(posedge core_clk);
		wr(OFF_CTRL, 32'h00000000);
		rd_chk(OFF_IRQ_FLAG, 32'h00000004, 32'h00000004);
		w16(OFF_CNT_HI, 16'h0DEF);
		wr(OFF_IRQ_FLAG, 32'h0000003C);
		for (k = 0; k < 2; k++) begin
			wv = {wave_out_a, wave_out_b};
			wr(OFF_CTRL, 32'h00000040 << k);
			repeat (2) @(posedge core_clk);
			chk({30'h0, wave_out_a, wave_out_b}, {30'h0, wv ^ (2'b10 >> k)}, 32'h00000003);
		end
		rd_chk(OFF_IRQ_FLAG, 32'h00000000, 32'h00000018);
		wr(OFF_CTRL, 32'h00000020);
		edge_to(1'b1);
		rd_chk(OFF_IRQ_FLAG, 32'h00000020, 32'h00000020);
		r16(OFF_SNAP_HI, 16'h0DEF);
		wr(OFF_IRQ_MASK, 32'h00000020);
		chk_port(4'h8);
		wr(OFF_IRQ_MASK, 32'h00000000);
		w16(OFF_CNT_HI, 16'h0ABC);
		wr(OFF_IRQ_FLAG, 32'h00000020);
		edge_to(1'b0);
		rd_chk(OFF_IRQ_FLAG, 32'h00000000, 32'h00000020);
		wr(OFF_CTRL, 32'h00000000);
		edge_to(1'b1);
		rd_chk(OFF_IRQ_FLAG, 32'h00000000, 32'h00000020);
		edge_to(1'b0);
		rd_chk(OFF_IRQ_FLAG, 32'h00000020, 32'h00000020);
		r16(OFF_SNAP_HI, 16'h0ABC);
		// capture register as top: pin edges must be ignored, flag marks top instead
		wr(OFF_CTRL, {28'h0, MODE_CTC_SNAP});
		w16(OFF_SNAP_HI, 16'h0008);
		w16(OFF_CNT_HI, 16'h0000);
		wr(OFF_IRQ_FLAG, 32'h0000003C);
		edge_to(1'b1);
		edge_to(1'b0);
		rd_chk(OFF_IRQ_FLAG, 32'h00000000, 32'h00000020);
		wr(OFF_CTRL, {28'h1, MODE_CTC_SNAP});
		repeat (30) @(posedge core_clk);
		wr(OFF_CTRL, {28'h0, MODE_CTC_SNAP});
		rd_chk(OFF_IRQ_FLAG, 32'h00000020, 32'h00000024);
		r16(OFF_SNAP_HI, 16'h0008);
		close_out();
	end
endmodule
